//--- rtl/mute_lock_pkg.sv
// shared constants for lock detection and soft mute
package mute_lock_pkg;

  // ****************************************************************
  // clock and timing
  // ****************************************************************
  localparam int          CLK_HZ           = 100_000_000;
  localparam int          FS_MIN_HZ        = 28_000;
  localparam int          FS_MAX_HZ        = 100_000;
  // longest accepted sample period rounds down, shortest rounds up
  localparam int          PERIOD_MAX_CYC   = CLK_HZ / FS_MIN_HZ;
  localparam int          PERIOD_MIN_CYC   = (CLK_HZ + FS_MAX_HZ - 1) / FS_MAX_HZ;
  localparam int          PERIOD_W         = 12;
  localparam int          RAMP_STEPS       = 32;
  localparam int          SAMPLES_PER_STEP = 32;
  localparam int          GAIN_W           = 16;

  // ****************************************************************
  // register map (byte addresses)
  // ****************************************************************
  localparam int          ADDR_W           = 8;
  localparam logic [7:0]  CTRL_ADDR        = 8'h00;
  localparam logic [7:0]  STATUS_ADDR      = 8'h04;
  localparam logic [7:0]  IRQ_STAT_ADDR    = 8'h08;
  localparam logic [7:0]  IRQ_CLR_ADDR     = 8'h0c;
  localparam logic [7:0]  IRQ_EN_ADDR      = 8'h10;

  // ctrl fields and reset values
  localparam int          CTRL_MUTE_BIT    = 0;
  localparam int          CTRL_OOS_BIT     = 1;
  localparam logic [1:0]  CTRL_RESET       = 2'h3;

  // status fields
  localparam int          ST_PLL_LOCK      = 0;
  localparam int          ST_LOCK_OUT      = 1;
  localparam int          ST_RATE_OK       = 2;
  localparam int          ST_STATIC_MODE   = 3;
  localparam int          ST_FULL_MUTE     = 4;
  localparam int          ST_HARD_MUTE     = 5;

  // interrupt events
  localparam int          IRQ_N            = 3;
  localparam int          EV_LOCK_GAIN     = 0;
  localparam int          EV_LOCK_LOSS     = 1;
  localparam int          EV_RAMP_DONE     = 2;
  localparam logic [2:0]  IRQ_RESET        = 3'h0;

endpackage : mute_lock_pkg

//--- rtl/level_sync.sv
// two flip-flop synchroniser for pin levels
`timescale 1ns/10ps
module level_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             ref_clk,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;

  // first stage feeds only the second stage
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      meta_r   <= '0;
      sync_out <= '0;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule // level_sync

//--- rtl/cosine_ramp.sv
// raised-cosine gain ramp stepped by sample ticks
`timescale 1ns/10ps
module cosine_ramp
  import mute_lock_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              srst,
  input  wire logic              sample_tick,
  input  wire logic              mute_req,
  output logic      [GAIN_W-1:0] gain_r,
  output logic      [5:0]        pos_r,
  output logic                   done_r
);

  logic [4:0] sub_r;
  logic       at_end;
  logic [5:0] pos_nxt;

  // half-table of the attenuation curve, mirrored for the upper half
  function automatic logic [GAIN_W-1:0] atten(input logic [5:0] k);
    logic [4:0] m;
    logic [GAIN_W-1:0] h;
    m = (k > 6'h10) ? 5'(6'h20 - k) : k[4:0];
    case (m)
      5'h00: h = 16'h0000;  5'h01: h = 16'h004f;  5'h02: h = 16'h013b;
      5'h03: h = 16'h02c1;  5'h04: h = 16'h04df;  5'h05: h = 16'h078f;
      5'h06: h = 16'h0ac9;  5'h07: h = 16'h0e87;  5'h08: h = 16'h12bf;
      5'h09: h = 16'h1766;  5'h0a: h = 16'h1c71;  5'h0b: h = 16'h21d4;
      5'h0c: h = 16'h2782;  5'h0d: h = 16'h2d6c;  5'h0e: h = 16'h3383;
      5'h0f: h = 16'h39ba;  default: h = 16'h4000;
    endcase
    return (k > 6'h10) ? 16'h7fff - h : h;
  endfunction

  assign at_end  = mute_req ? (pos_r == 6'(RAMP_STEPS)) : (pos_r == 6'h00);
  assign pos_nxt = mute_req ? pos_r + 6'h01 : pos_r - 6'h01;

  // start fully muted so register-mode start-up is silent
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pos_r  <= 6'(RAMP_STEPS);
      sub_r  <= 5'h00;
      gain_r <= 16'h0000;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (at_end) begin
        sub_r <= 5'h00;
      end else if (sample_tick) begin
        sub_r <= sub_r + 5'h01;
        if (sub_r == 5'(SAMPLES_PER_STEP - 1)) begin
          pos_r  <= pos_nxt;
          done_r <= (pos_nxt == 6'(RAMP_STEPS)) || (pos_nxt == 6'h00);
        end
      end
      gain_r <= 16'h7fff - atten(pos_r);
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  sequence s_ramp_step;
    sample_tick && (pos_r != 6'h00) && (pos_r != 6'(RAMP_STEPS));
  endsequence

  a_step_progress: assert property (
    @(posedge ref_clk) disable iff (srst)
    s_ramp_step ##0 (sub_r == 5'(SAMPLES_PER_STEP - 1)) |=> $changed(pos_r))
    else $error("ramp did not step after 32 samples");

endmodule // cosine_ramp

//--- rtl/lock_detect_soft_mute.sv
// lock indication, auto mute and soft mute control
`timescale 1ns/10ps

module lock_detect_soft_mute
  import mute_lock_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              srst,
  input  wire logic              pll_lock_pin,
  input  wire logic              decoder_locked,
  input  wire logic              pcm_flag,
  input  wire logic              sample_tick,
  input  wire logic              control_mode_select,
  input  wire logic              mute_pin,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata,
  output logic                   lock_out_r,
  output logic                   hard_mute_r,
  output logic      [GAIN_W-1:0] gain_r,
  output logic                   irq_r
);

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [2:0] pins_s;
  logic       pll_s;
  logic       static_mode;
  logic       mute_pin_s;

  level_sync #(
    .WIDTH    (3)
  ) u_sync (
    .ref_clk  (ref_clk),
    .srst     (srst),
    .async_in ({mute_pin, control_mode_select, pll_lock_pin}),
    .sync_out (pins_s)
  );

  assign pll_s       = pins_s[0];
  assign static_mode = pins_s[1];
  assign mute_pin_s  = pins_s[2];

  // ****************************************************************
  // sample rate window
  // ****************************************************************
  logic [PERIOD_W-1:0] period_cnt_r;
  logic                rate_ok_r;
  logic                period_long;
  logic                period_in_range;

  assign period_long     = period_cnt_r > PERIOD_W'(PERIOD_MAX_CYC);
  assign period_in_range = !period_long && (period_cnt_r >= PERIOD_W'(PERIOD_MIN_CYC));

  // counter saturates so a dead input reads as out of range
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      period_cnt_r <= '0;
      rate_ok_r    <= 1'b0;
    end else if (sample_tick) begin
      period_cnt_r <= PERIOD_W'(1);
      rate_ok_r    <= period_in_range;
    end else begin
      if (!period_long) period_cnt_r <= period_cnt_r + PERIOD_W'(1);
      if (period_long) rate_ok_r <= 1'b0;
    end
  end

  // ****************************************************************
  // lock combination
  // ****************************************************************
  logic locked_w;
  logic lock_nxt;
  logic locked_d_r;

  assign locked_w = pll_s && decoder_locked && rate_ok_r;
  assign lock_nxt = locked_w && pcm_flag;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      lock_out_r <= 1'b0;
      locked_d_r <= 1'b0;
    end else begin
      lock_out_r <= lock_nxt;
      locked_d_r <= locked_w;
    end
  end

  // ****************************************************************
  // control register and mute selection
  // ****************************************************************
  logic [1:0] ctrl_r;
  logic       mute_bit;
  logic       oos_enable;
  logic       mute_req_w;
  logic       hard_nxt;

  assign mute_bit   = ctrl_r[CTRL_MUTE_BIT];
  assign oos_enable = ctrl_r[CTRL_OOS_BIT];
  // register mode never looks at the pin
  assign mute_req_w = static_mode ? mute_pin_s : mute_bit;
  assign hard_nxt   = oos_enable && !locked_w;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      hard_mute_r <= 1'b1;
    end else begin
      hard_mute_r <= hard_nxt;
    end
  end

  // ****************************************************************
  // soft mute ramp
  // ****************************************************************
  logic [5:0] ramp_pos;
  logic       ramp_done;

  cosine_ramp u_ramp (
    .ref_clk     (ref_clk),
    .srst        (srst),
    .sample_tick (sample_tick),
    .mute_req    (mute_req_w),
    .gain_r      (gain_r),
    .pos_r       (ramp_pos),
    .done_r      (ramp_done)
  );

  // ****************************************************************
  // register port
  // ****************************************************************
  logic             wr_ctrl;
  logic             wr_clr;
  logic             wr_en;
  logic [IRQ_N-1:0] irq_stat_r;
  logic [IRQ_N-1:0] irq_en_r;
  logic [IRQ_N-1:0] events_w;
  logic [IRQ_N-1:0] irq_stat_nxt;
  logic [31:0]      status_w;
  logic [31:0]      rdata_nxt;

  assign wr_ctrl = reg_wr && (reg_addr == CTRL_ADDR);
  assign wr_clr  = reg_wr && (reg_addr == IRQ_CLR_ADDR);
  assign wr_en   = reg_wr && (reg_addr == IRQ_EN_ADDR);

  assign status_w = {26'h0, hard_mute_r, (ramp_pos == 6'(RAMP_STEPS)), static_mode,
                     rate_ok_r, lock_out_r, pll_s};

  assign rdata_nxt = (reg_addr == CTRL_ADDR)     ? {30'h0, ctrl_r} :
                     (reg_addr == STATUS_ADDR)   ? status_w :
                     (reg_addr == IRQ_STAT_ADDR) ? {29'h0, irq_stat_r} :
                     (reg_addr == IRQ_EN_ADDR)   ? {29'h0, irq_en_r} :
                     32'h0;

  assign events_w[EV_LOCK_GAIN] = locked_w && !locked_d_r;
  assign events_w[EV_LOCK_LOSS] = !locked_w && locked_d_r;
  assign events_w[EV_RAMP_DONE] = ramp_done;

  // a new event wins over a clear in the same cycle
  assign irq_stat_nxt = (irq_stat_r & ~(wr_clr ? reg_wdata[IRQ_N-1:0] : '0)) | events_w;

  // mute bit resets set, so in register mode the controller must clear it for audio
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ctrl_r     <= CTRL_RESET;
      irq_stat_r <= IRQ_RESET;
      irq_en_r   <= IRQ_RESET;
      irq_r      <= 1'b0;
      reg_rdata  <= 32'h0;
    end else begin
      if (wr_ctrl) ctrl_r <= reg_wdata[1:0];
      if (wr_en) irq_en_r <= reg_wdata[IRQ_N-1:0];
      irq_stat_r <= irq_stat_nxt;
      irq_r      <= |(irq_stat_nxt & (wr_en ? reg_wdata[IRQ_N-1:0] : irq_en_r));
      reg_rdata  <= reg_rd ? rdata_nxt : 32'h0;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  // a status read answers in the next cycle only
  sequence s_status_read;
    reg_rd && (reg_addr == STATUS_ADDR);
  endsequence

  a_lock_needs_all: assert property (
    lock_out_r |-> $past(pll_s) && $past(decoder_locked) && $past(pcm_flag) && $past(rate_ok_r))
    else $error("lock output high without full lock and pcm");

  a_nonpcm_drops_lock: assert property (
    (locked_w && !pcm_flag) |=> !lock_out_r)
    else $error("lock output stayed high on non-pcm stream");

  a_status_pll_bit: assert property (
    (reg_rd && reg_addr == STATUS_ADDR) |=> reg_rdata[ST_PLL_LOCK] == $past(pll_s))
    else $error("status read does not show clock lock");

  a_static_pin_mutes: assert property (
    (static_mode && mute_pin_s && sample_tick && ramp_pos != 6'(RAMP_STEPS))
      |=> ramp_pos >= $past(ramp_pos))
    else $error("ramp moved toward audio under a pin mute request");

  a_ramp_only_on_tick: assert property (
    $changed(ramp_pos) |-> $past(sample_tick) && $past(mute_req_w) == (ramp_pos > $past(ramp_pos)))
    else $error("ramp position moved without a sample or the wrong way");

  a_ramp_bounded: assert property (
    ramp_pos <= 6'(RAMP_STEPS))
    else $error("ramp position beyond the mute end");

  a_start_muted: assert property (
    $fell(srst) |-> ctrl_r[CTRL_MUTE_BIT] && ramp_pos == 6'(RAMP_STEPS) ##1 gain_r == 16'h0000)
    else $error("device did not start muted");

  a_pin_ignored: assert property (
    (!static_mode && $changed(mute_pin_s) && $stable(ctrl_r) && $stable(static_mode))
      |-> $stable(mute_req_w))
    else $error("mute pin acted in register mode");

  a_rate_too_slow: assert property (
    (sample_tick && period_cnt_r > PERIOD_W'(PERIOD_MAX_CYC)) |=> !rate_ok_r [*2])
    else $error("slow sample rate accepted");

  a_hard_mute_unlocked: assert property (
    (oos_enable && !locked_w) |=> hard_mute_r)
    else $error("no hard mute while unlocked");

  a_auto_mute_off: assert property (
    (wr_ctrl && !reg_wdata[CTRL_OOS_BIT]) |=> ##1 !hard_mute_r)
    else $error("hard mute remained after auto mute disabled");

  a_irq_set_wins: assert property (
    (events_w[EV_LOCK_GAIN] && wr_clr) |=> irq_stat_r[EV_LOCK_GAIN])
    else $error("lock gain event lost to a clear");

  a_lock_when_all: assert property (
    lock_nxt |=> lock_out_r)
    else $error("lock output low although fully locked on pcm");

  a_lock_needs_clock: assert property (
    !pll_s |=> !lock_out_r)
    else $error("lock output high without clock lock");

  a_lock_needs_decoder: assert property (
    !decoder_locked |=> !lock_out_r)
    else $error("lock output high without decoder lock");

  a_nonpcm_lock_low: assert property (
    !pcm_flag |=> !lock_out_r)
    else $error("lock output high on non-pcm stream");

  a_status_lock_out: assert property (
    s_status_read |=> reg_rdata[ST_LOCK_OUT] == $past(lock_out_r))
    else $error("status read does not show lock output");

  a_status_rate_ok: assert property (
    s_status_read |=> reg_rdata[ST_RATE_OK] == $past(rate_ok_r))
    else $error("status read does not show rate window");

  a_status_mode_bit: assert property (
    s_status_read |=> reg_rdata[ST_STATIC_MODE] == $past(static_mode))
    else $error("status read does not show control mode");

  a_status_hard_mute: assert property (
    s_status_read |=> reg_rdata[ST_HARD_MUTE] == $past(hard_mute_r))
    else $error("status read does not show hard mute");

  a_status_full_mute: assert property (
    s_status_read |=> reg_rdata[ST_FULL_MUTE] == ($past(ramp_pos) == 6'(RAMP_STEPS)))
    else $error("status read does not show full soft mute");

  a_status_high_zero: assert property (
    s_status_read |=> reg_rdata[31:6] == 26'h0)
    else $error("unused status bits not zero");

  a_rdata_idle_zero: assert property (
    !reg_rd |=> reg_rdata == 32'h0)
    else $error("read data not zero outside a read");

  a_ctrl_read_back: assert property (
    (reg_rd && reg_addr == CTRL_ADDR) |=> reg_rdata == {30'h0, $past(ctrl_r)})
    else $error("control read does not return control register");

  a_ctrl_write_lands: assert property (
    wr_ctrl |=> ctrl_r == $past(reg_wdata[1:0]))
    else $error("control write did not land");

  a_reg_unmute: assert property (
    (!static_mode && !mute_bit && sample_tick && ramp_pos != 6'h00)
      |=> ramp_pos <= $past(ramp_pos))
    else $error("ramp moved toward mute with the mute bit clear");

  a_pin_unmute: assert property (
    (static_mode && !mute_pin_s && sample_tick && ramp_pos != 6'h00)
      |=> ramp_pos <= $past(ramp_pos))
    else $error("ramp moved toward mute with the pin low");

  a_gain_muted_end: assert property (
    (ramp_pos == 6'(RAMP_STEPS)) |=> gain_r == 16'h0000)
    else $error("gain not zero at the mute end");

  a_gain_open_end: assert property (
    (ramp_pos == 6'h00) |=> gain_r == 16'h7fff)
    else $error("gain not full at the audio end");

  a_rate_too_fast: assert property (
    (sample_tick && period_cnt_r < PERIOD_W'(PERIOD_MIN_CYC)) |=> !rate_ok_r)
    else $error("fast sample rate accepted");

  a_rate_in_window: assert property (
    (sample_tick && period_in_range) |=> rate_ok_r)
    else $error("in-range sample rate refused");

  a_rate_long_drop: assert property (
    period_long |=> !rate_ok_r)
    else $error("rate window held after a missing sample");

  a_unmute_when_locked: assert property (
    locked_w |=> !hard_mute_r)
    else $error("hard mute while locked");

  a_auto_mute_cleared: assert property (
    !oos_enable |=> !hard_mute_r)
    else $error("hard mute with auto mute disabled");

  a_irq_level: assert property (
    irq_r == |(irq_stat_r & irq_en_r))
    else $error("interrupt level does not match enabled status");

  a_irq_clear_lands: assert property (
    (wr_clr && reg_wdata[EV_RAMP_DONE] && !events_w[EV_RAMP_DONE])
      |=> !irq_stat_r[EV_RAMP_DONE])
    else $error("ramp done status survived a clear");

  a_lock_loss_event: assert property (
    events_w[EV_LOCK_LOSS] |=> irq_stat_r[EV_LOCK_LOSS])
    else $error("lock loss not recorded");

endmodule // lock_detect_soft_mute

//--- tb/iec_source_model.sv
// stream source model: sample ticks, clock lock, decoder lock and pcm level
`timescale 1ns/10ps
module iec_source_model (
  input  wire logic        ref_clk,
  input  wire logic [11:0] period,
  input  wire logic        link_up,
  input  wire logic        pcm_on,
  output logic             pll_lock_pin,
  output logic             decoder_locked,
  output logic             pcm_flag,
  output logic             sample_tick
);
  logic [11:0] cnt_r;

  initial begin
    cnt_r = 12'h000;
    pll_lock_pin = 1'b0;
    decoder_locked = 1'b0;
    pcm_flag = 1'b0;
    sample_tick = 1'b0;
  end

  // ****************************************************************
  // tick spacing and lock levels
  // ****************************************************************
  always @(posedge ref_clk) begin
    // spacing is what the bench asks for, in range or deliberately out of it
    if (cnt_r >= period - 12'h001) begin
      cnt_r <= 12'h000;
      sample_tick <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 12'h001;
      sample_tick <= 1'b0;
    end
    pll_lock_pin <= link_up;
    // decoder rises a cycle after the clock lock, as a real one would, but drops with it
    decoder_locked <= pll_lock_pin & link_up;
    pcm_flag <= pcm_on;
  end
endmodule // iec_source_model

//--- tb/lock_detect_soft_mute_bench.sv
// self-checking bench for lock indication, auto mute and soft mute
`timescale 1ns/10ps
module lock_detect_soft_mute_bench
  import mute_lock_pkg::*;
;
  logic              ref_clk = 1'b0;
  logic              srst = 1'b1;
  logic              control_mode_select = 1'b0;
  logic              mute_pin = 1'b0;
  logic [ADDR_W-1:0] reg_addr = 8'h00;
  logic [31:0]       reg_wdata = 32'h0000_0000;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic [31:0]       reg_rdata;
  logic              lock_out_r, hard_mute_r, irq_r;
  logic [GAIN_W-1:0] gain_r;
  logic              pll_lock_pin, decoder_locked, pcm_flag, sample_tick;
  logic [11:0]       period = 12'h004;
  logic              link_up = 1'b0;
  logic              pcm_on = 1'b1;
  logic [31:0]       rd_val;
  int                mismatches = 0;
  int                checks_done = 0;
  int                cycles = 0;

  always #5 ref_clk = ~ref_clk;

  iec_source_model iec_source_model_inst (
    .ref_clk(ref_clk), .period(period), .link_up(link_up), .pcm_on(pcm_on),
    .pll_lock_pin(pll_lock_pin), .decoder_locked(decoder_locked),
    .pcm_flag(pcm_flag), .sample_tick(sample_tick));

  lock_detect_soft_mute lock_detect_soft_mute_inst (
    .ref_clk(ref_clk), .srst(srst), .pll_lock_pin(pll_lock_pin),
    .decoder_locked(decoder_locked), .pcm_flag(pcm_flag), .sample_tick(sample_tick),
    .control_mode_select(control_mode_select), .mute_pin(mute_pin),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .lock_out_r(lock_out_r), .hard_mute_r(hard_mute_r),
    .gain_r(gain_r), .irq_r(irq_r));

  // ****************************************************************
  // bus, wait and compare tasks
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      while (sample_tick !== 1'b1) @(posedge ref_clk);
    end
    repeat (4) @(posedge ref_clk);
    #1;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // run takes about 31k cycles; the ceiling leaves nearly three times that
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 90000) begin
      mismatches++;
      complete_run();
    end
  end

  // ****************************************************************
  // scenarios
  // ****************************************************************
  initial begin
    repeat (20) @(posedge ref_clk);
    srst <= 1'b0;
    settle(1);
    check(lock_out_r, 1'b0);
    check(hard_mute_r, 1'b1);
    check(gain_r, 16'h0000);
    rd(CTRL_ADDR, rd_val);
    check(rd_val, 32'h3);
    rd(STATUS_ADDR, rd_val);
    check(rd_val & 32'h8, 32'h0);
    // register mode: pin asks for mute but must be ignored, bit keeps it muted
    mute_pin <= 1'b1;
    ticks(1100);
    check(gain_r, 16'h0000);
    wr(CTRL_ADDR, 32'h2);
    ticks(992);
    check(gain_r == 16'h7fff, 1'b0);
    ticks(34);
    check(gain_r, 16'h7fff);
    rd(IRQ_STAT_ADDR, rd_val);
    check(rd_val & 32'h4, 32'h4);
    check(irq_r, 1'b0);
    wr(IRQ_EN_ADDR, 32'h4);
    settle(2);
    check(irq_r, 1'b1);
    wr(IRQ_CLR_ADDR, 32'h4);
    wr(IRQ_STAT_ADDR, 32'h7);
    settle(2);
    check(irq_r, 1'b0);
    rd(IRQ_STAT_ADDR, rd_val);
    check(rd_val, 32'h0);
    rd(8'h14, rd_val);
    check(rd_val, 32'h0);
    // unlocked: hard mute on until the auto mute enable is cleared
    check(hard_mute_r, 1'b1);
    wr(CTRL_ADDR, 32'h0);
    settle(2);
    check(hard_mute_r, 1'b0);
    wr(CTRL_ADDR, 32'h2);
    settle(2);
    check(hard_mute_r, 1'b1);
    // lock at a mid-range rate
    wr(IRQ_EN_ADDR, 32'h1);
    period <= 12'h8db;
    link_up <= 1'b1;
    ticks(3);
    check(lock_out_r, 1'b1);
    check(hard_mute_r, 1'b0);
    check(irq_r, 1'b1);
    rd(STATUS_ADDR, rd_val);
    check(rd_val & 32'h7, 32'h7);
    pcm_on <= 1'b0;
    settle(4);
    check(lock_out_r, 1'b0);
    check(hard_mute_r, 1'b0);
    pcm_on <= 1'b1;
    settle(4);
    check(lock_out_r, 1'b1);
    // just too slow a stream: rate check drops the lock
    period <= 12'he10;
    ticks(1);
    settle(3600);
    check(lock_out_r, 1'b0);
    check(hard_mute_r, 1'b1);
    rd(STATUS_ADDR, rd_val);
    check(rd_val & 32'h4, 32'h0);
    rd(IRQ_STAT_ADDR, rd_val);
    check(rd_val & 32'h2, 32'h2);
    // static mode: pin now drives the soft mute, control bit says unmuted
    wr(CTRL_ADDR, 32'h0);
    period <= 12'h004;
    control_mode_select <= 1'b1;
    ticks(1100);
    check(gain_r, 16'h0000);
    rd(STATUS_ADDR, rd_val);
    check(rd_val & 32'h8, 32'h8);
    mute_pin <= 1'b0;
    ticks(1100);
    check(gain_r, 16'h7fff);
    complete_run();
  end
endmodule // lock_detect_soft_mute_bench
